// file: common/adc_ctrl_pkg.sv
// constants shared by the conversion control block and its helpers
// assumes a single 125 MHz clock and an APB register port with 32-bit data
package adc_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SMP_W = 12;
    localparam int RES_W = 16;
    localparam int SUM_W = 22;
    // register byte addresses
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_AVG = 8'h08;
    localparam logic [7:0] OFS_SAMP = 8'h0C;
    localparam logic [7:0] OFS_INPUT = 8'h10;
    localparam logic [7:0] OFS_EVCTL = 8'h14;
    localparam logic [7:0] OFS_SOFTWARE_TRIGGER_REG = 8'h18;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE_SET_REG = 8'h1C;
    localparam logic [7:0] OFS_INTENCLR = 8'h20;
    localparam logic [7:0] OFS_INTERRUPT_FLAG_REG = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_RESULT = 8'h2C;
    localparam logic [7:0] OFS_DBG = 8'h30;
    // field positions
    localparam int BIT_SOFT_RESET_BIT = 0;
    localparam int BIT_ENABLE = 1;
    localparam int BIT_DIFF = 0;
    localparam int BIT_FREERUN = 1;
    localparam int POS_RES = 4;
    localparam int POS_PRESC = 8;
    localparam int BIT_START = 1;
    localparam int BIT_RESULT_READY_FLAG = 0;
    localparam int BIT_OVERRUN = 1;
    localparam int BIT_SYNCBUSY = 7;
    // resolution codes, reset values
    localparam logic [1:0] RES_12 = 2'h0;
    localparam logic [1:0] RES_ACC = 2'h1;
    localparam logic [1:0] RES_10 = 2'h2;
    localparam logic [1:0] RES_8 = 2'h3;
    localparam logic [2:0] PRESC_RST = 3'h0;
    localparam logic [3:0] AVG_MAX_CODE = 4'hA;
    localparam logic [3:0] AVG_NOSHIFT_CODE = 4'h4;
    localparam logic [3:0] GAIN_DEF_CODE = 4'hF;
    localparam logic [3:0] GAIN_LAST_CODE = 4'h4;
    // bus-to-converter transfer takes this many clock cycles
    localparam logic [1:0] SYNC_CYCLES = 2'h3;
endpackage

// file: core/adc_prescaler.sv
// divides the conversion clock by a power of two
// assumes one clock; the division code is held stable while enabled
`timescale 1ns/1ps
`default_nettype none
module adc_prescaler (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_enable,
    input wire logic [2:0] i_div_code,
    output logic o_tick,
    output logic o_half
);
    logic [8:0] cnt_r;
    logic [9:0] div;

    // ratio is 4 << code, code 0 is the smallest
    assign div = 10'h004 << i_div_code;

    always_ff @(posedge i_clk) begin
        if (i_srst || !i_enable) begin
            cnt_r <= 9'h000;
            o_tick <= 1'b0;
            o_half <= 1'b0;
        end else begin
            o_tick <= ({1'b0, cnt_r} == div - 10'h001);
            o_half <= ({1'b0, cnt_r} == (div >> 1) - 10'h001);
            cnt_r <= ({1'b0, cnt_r} == div - 10'h001) ? 9'h000 : cnt_r + 9'h001;
        end
    end
endmodule
`default_nettype wire

// file: core/adc_accumulator.sv
// sums consecutive samples and shifts large sums down into 16 bits
// assumes one sample pulse at a time, code stable during a run
`timescale 1ns/1ps
`default_nettype none
module adc_accumulator (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_clear,
    input wire logic i_valid,
    input wire logic [11:0] i_sample,
    input wire logic [3:0] i_code,
    output logic o_last,
    output logic o_done,
    output logic [15:0] o_result
);
    logic [21:0] sum_r;
    logic [10:0] cnt_r;
    logic [21:0] total;
    logic [10:0] target;
    logic [3:0] shift;

    // reserved codes act as one sample
    assign target = (i_code <= adc_ctrl_pkg::AVG_MAX_CODE) ? (11'h001 << i_code) : 11'h001;
    assign shift = (i_code > adc_ctrl_pkg::AVG_NOSHIFT_CODE && i_code <= adc_ctrl_pkg::AVG_MAX_CODE) ?
        i_code - adc_ctrl_pkg::AVG_NOSHIFT_CODE : 4'h0;
    assign total = sum_r + {10'h000, i_sample};
    assign o_last = (cnt_r + 11'h001 == target);

    always_ff @(posedge i_clk) begin
        if (i_srst || i_clear) begin
            sum_r <= 22'h000000;
            cnt_r <= 11'h000;
            o_done <= 1'b0;
            o_result <= 16'h0000;
        end else begin
            o_done <= i_valid && o_last;
            if (i_valid && o_last) begin
                o_result <= 16'(total >> shift);
                sum_r <= 22'h000000;
                cnt_r <= 11'h000;
            end else if (i_valid) begin
                sum_r <= total;
                cnt_r <= cnt_r + 11'h001;
            end
        end
    end
endmodule
`default_nettype wire

// file: core/adc_conversion_control.sv
// register file, trigger logic and conversion sequencer of a 12-bit SAR converter
// assumes APB master on i_clk; analog core data and event input are asynchronous
//
// Summary of operation
// - enable bit set starts the converter, cleared stops it
// - soft reset restores all registers but debug control, converter off
// - a conversion starts on software start bit or enabled event trigger
// - free-running mode restarts a conversion whenever one finishes
// - each finished value overwrites the result register
// - result ready flag sets once per accumulated result, after the last sample of a run
// - a new result before the old one is read sets overrun
// - interrupt request only for flags whose enable bit is set
// - input sampled in first half period, lengthened by sampling length
// - latency is one plus half resolution plus gain delay periods
// - gain delay follows gain code and differential or single-ended mode
// - resolution selects 8, 10 or 12 bits, 12 after reset
// - differential select chooses mode, either mode single or free-running
// - sample count code accumulates two to its power samples
// - above 16 samples the sum shifts right by code minus four
// - an internal prescaler divides the conversion clock
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_event_start,
    input wire logic [11:0] i_core_data,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_irq,
    output logic o_core_enable,
    output logic o_core_sample,
    output logic o_core_diff,
    output logic [3:0] o_core_gain,
    output logic [1:0] o_core_res
);
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_e;

    function automatic logic is_synced(input logic [7:0] a);
        is_synced = (a == adc_ctrl_pkg::OFS_CTRL_A) || (a == adc_ctrl_pkg::OFS_CTRL_B) ||
            (a == adc_ctrl_pkg::OFS_AVG) || (a == adc_ctrl_pkg::OFS_SAMP) ||
            (a == adc_ctrl_pkg::OFS_INPUT) || (a == adc_ctrl_pkg::OFS_SOFTWARE_TRIGGER_REG);
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = is_synced(a) || (a == adc_ctrl_pkg::OFS_EVCTL) || (a == adc_ctrl_pkg::OFS_INTERRUPT_ENABLE_SET_REG) ||
            (a == adc_ctrl_pkg::OFS_INTENCLR) || (a == adc_ctrl_pkg::OFS_INTERRUPT_FLAG_REG) ||
            (a == adc_ctrl_pkg::OFS_STATUS) || (a == adc_ctrl_pkg::OFS_RESULT) || (a == adc_ctrl_pkg::OFS_DBG);
    endfunction

    function automatic logic [3:0] half_res(input logic [1:0] res);
        case (res)
            adc_ctrl_pkg::RES_10: half_res = 4'h5;
            adc_ctrl_pkg::RES_8: half_res = 4'h4;
            default: half_res = 4'h6;
        endcase
    endfunction

    function automatic logic [3:0] gain_delay(input logic diff, input logic [3:0] g);
        if (g == adc_ctrl_pkg::GAIN_DEF_CODE) begin
            gain_delay = diff ? 4'h0 : 4'h1;
        end else if (g > adc_ctrl_pkg::GAIN_LAST_CODE) begin
            gain_delay = 4'h0;
        end else if (diff) begin
            gain_delay = {2'h0, g[2:1]};
        end else begin
            gain_delay = {2'h0, 2'(({1'b0, g[2:0]} + 4'h1) >> 1)};
        end
    endfunction

    // bus-side register copies
    logic soft_reset_bit_r, rst;
    logic enable_r, diff_r, free_r, evstart_r, dbg_r, software_trigger_reg_req_r;
    logic [1:0] res_r, flags_r, inten_r, sync_cnt_r;
    logic [2:0] presc_r;
    logic [3:0] avg_r, gain_r;
    logic [5:0] sampling_length_r;
    logic [15:0] result_r;
    // converter-side copies
    logic eng_free_r;
    logic [2:0] eng_presc_r;
    logic [3:0] eng_avg_r;
    logic [5:0] eng_sampling_length_r;
    // sequencer
    conv_state_e state_r;
    logic start_pend_r, auto_r, acc_valid_r;
    logic [5:0] ext_r;
    logic [3:0] lat_r;
    logic [11:0] smp_r;
    logic [2:0] ev_sync_r;
    logic [11:0] data_s1_r, data_s2_r;
    logic tick, half, acc_last, acc_done;
    logic [15:0] acc_result;
    logic access, commit, wr, rd, sync_busy, sync_done, ev_edge, rd_result, go;
    logic [31:0] rdata;

    assign rst = i_srst || soft_reset_bit_r;
    assign access = i_psel && i_penable;
    assign commit = access && o_pready;
    assign wr = commit && i_pwrite && is_mapped(i_paddr);
    assign rd = commit && !i_pwrite;
    assign sync_busy = (sync_cnt_r != 2'h0);
    assign sync_done = (sync_cnt_r == 2'h1);
    assign rd_result = rd && (i_paddr == adc_ctrl_pkg::OFS_RESULT);
    assign ev_edge = ev_sync_r[1] && !ev_sync_r[2];
    assign go = o_core_enable && tick && (start_pend_r || auto_r);

    always_comb begin
        rdata = 32'h00000000;
        case (i_paddr)
            adc_ctrl_pkg::OFS_CTRL_A: begin
                rdata[adc_ctrl_pkg::BIT_SOFT_RESET_BIT] = soft_reset_bit_r;
                rdata[adc_ctrl_pkg::BIT_ENABLE] = enable_r;
            end
            adc_ctrl_pkg::OFS_CTRL_B: begin
                rdata[adc_ctrl_pkg::BIT_DIFF] = diff_r;
                rdata[adc_ctrl_pkg::BIT_FREERUN] = free_r;
                rdata[adc_ctrl_pkg::POS_RES +: 2] = res_r;
                rdata[adc_ctrl_pkg::POS_PRESC +: 3] = presc_r;
            end
            adc_ctrl_pkg::OFS_AVG: rdata[3:0] = avg_r;
            adc_ctrl_pkg::OFS_SAMP: rdata[5:0] = sampling_length_r;
            adc_ctrl_pkg::OFS_INPUT: rdata[3:0] = gain_r;
            adc_ctrl_pkg::OFS_EVCTL: rdata[0] = evstart_r;
            adc_ctrl_pkg::OFS_INTERRUPT_ENABLE_SET_REG: rdata[1:0] = inten_r;
            adc_ctrl_pkg::OFS_INTENCLR: rdata[1:0] = inten_r;
            adc_ctrl_pkg::OFS_INTERRUPT_FLAG_REG: rdata[1:0] = flags_r;
            adc_ctrl_pkg::OFS_STATUS: begin
                rdata[adc_ctrl_pkg::BIT_SYNCBUSY] = sync_busy;
                rdata[0] = (state_r != ST_IDLE);
            end
            adc_ctrl_pkg::OFS_RESULT: rdata[15:0] = result_r;
            adc_ctrl_pkg::OFS_DBG: rdata[0] = dbg_r;
            default: rdata = 32'h00000000;
        endcase
    end

    // apb answer: ready one cycle into the access, held off for writes to synced registers while a transfer is busy
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h00000000;
        end else if (commit) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (access && !(i_pwrite && is_synced(i_paddr) && sync_busy)) begin
            o_pready <= 1'b1;
            o_pslverr <= !is_mapped(i_paddr);
            o_prdata <= i_pwrite ? 32'h00000000 : rdata;
        end
    end

    // soft reset pulse, debug control survives it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            soft_reset_bit_r <= 1'b0;
            dbg_r <= 1'b0;
        end else begin
            soft_reset_bit_r <= wr && (i_paddr == adc_ctrl_pkg::OFS_CTRL_A) && i_pwdata[adc_ctrl_pkg::BIT_SOFT_RESET_BIT];
            if (wr && i_paddr == adc_ctrl_pkg::OFS_DBG) begin
                dbg_r <= i_pwdata[0];
            end
        end
    end

    // configuration registers
    always_ff @(posedge i_clk) begin
        if (rst) begin
            enable_r <= 1'b0;
            diff_r <= 1'b0;
            free_r <= 1'b0;
            res_r <= adc_ctrl_pkg::RES_12;
            presc_r <= adc_ctrl_pkg::PRESC_RST;
            avg_r <= 4'h0;
            sampling_length_r <= 6'h00;
            gain_r <= 4'h0;
            evstart_r <= 1'b0;
            inten_r <= 2'h0;
        end else if (wr) begin
            case (i_paddr)
                adc_ctrl_pkg::OFS_CTRL_A: enable_r <= i_pwdata[adc_ctrl_pkg::BIT_ENABLE];
                adc_ctrl_pkg::OFS_CTRL_B: begin
                    diff_r <= i_pwdata[adc_ctrl_pkg::BIT_DIFF];
                    free_r <= i_pwdata[adc_ctrl_pkg::BIT_FREERUN];
                    res_r <= i_pwdata[adc_ctrl_pkg::POS_RES +: 2];
                    presc_r <= i_pwdata[adc_ctrl_pkg::POS_PRESC +: 3];
                end
                adc_ctrl_pkg::OFS_AVG: avg_r <= i_pwdata[3:0];
                adc_ctrl_pkg::OFS_SAMP: sampling_length_r <= i_pwdata[5:0];
                adc_ctrl_pkg::OFS_INPUT: gain_r <= i_pwdata[3:0];
                adc_ctrl_pkg::OFS_EVCTL: evstart_r <= i_pwdata[0];
                adc_ctrl_pkg::OFS_INTERRUPT_ENABLE_SET_REG: inten_r <= inten_r | i_pwdata[1:0];
                adc_ctrl_pkg::OFS_INTENCLR: inten_r <= inten_r & ~i_pwdata[1:0];
                default: inten_r <= inten_r;
            endcase
        end
    end

    // transfer of bus writes to the converter side
    always_ff @(posedge i_clk) begin
        if (rst) begin
            sync_cnt_r <= 2'h0;
            software_trigger_reg_req_r <= 1'b0;
            o_core_enable <= 1'b0;
            o_core_diff <= 1'b0;
            o_core_res <= adc_ctrl_pkg::RES_12;
            o_core_gain <= 4'h0;
            eng_free_r <= 1'b0;
            eng_presc_r <= adc_ctrl_pkg::PRESC_RST;
            eng_avg_r <= 4'h0;
            eng_sampling_length_r <= 6'h00;
        end else begin
            if (wr && is_synced(i_paddr)) begin
                sync_cnt_r <= adc_ctrl_pkg::SYNC_CYCLES;
            end else if (sync_busy) begin
                sync_cnt_r <= sync_cnt_r - 2'h1;
            end
            if (wr && i_paddr == adc_ctrl_pkg::OFS_SOFTWARE_TRIGGER_REG && i_pwdata[adc_ctrl_pkg::BIT_START]) begin
                software_trigger_reg_req_r <= 1'b1;
            end else if (sync_done) begin
                software_trigger_reg_req_r <= 1'b0;
            end
            if (sync_done) begin
                o_core_enable <= enable_r;
                o_core_diff <= diff_r;
                o_core_res <= res_r;
                o_core_gain <= gain_r;
                eng_free_r <= free_r;
                eng_presc_r <= presc_r;
                eng_avg_r <= avg_r;
                eng_sampling_length_r <= sampling_length_r;
            end
        end
    end

    // event pin and core data pass two flops first
    always_ff @(posedge i_clk) begin
        if (rst) begin
            ev_sync_r <= 3'h0;
            data_s1_r <= 12'h000;
            data_s2_r <= 12'h000;
        end else begin
            ev_sync_r <= {ev_sync_r[1:0], i_event_start};
            data_s1_r <= i_core_data;
            data_s2_r <= data_s1_r;
        end
    end

    // start request: set by software start or enabled event, cleared when a conversion begins
    always_ff @(posedge i_clk) begin
        if (rst || !o_core_enable) begin
            start_pend_r <= 1'b0;
        end else if ((sync_done && software_trigger_reg_req_r) || (evstart_r && ev_edge)) begin
            start_pend_r <= 1'b1;
        end else if (go) begin
            start_pend_r <= 1'b0;
        end
    end

    adc_prescaler u_presc (
        .i_clk(i_clk),
        .i_srst(rst),
        .i_enable(o_core_enable),
        .i_div_code(eng_presc_r),
        .o_tick(tick),
        .o_half(half)
    );

    // conversion sequencer on the prescaled period
    always_ff @(posedge i_clk) begin
        if (rst || !o_core_enable) begin
            state_r <= ST_IDLE;
            o_core_sample <= 1'b0;
            auto_r <= 1'b0;
            acc_valid_r <= 1'b0;
            ext_r <= 6'h00;
            lat_r <= 4'h0;
            smp_r <= 12'h000;
        end else begin
            acc_valid_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (go) begin
                        state_r <= ST_SAMPLE;
                        o_core_sample <= 1'b1;
                        auto_r <= 1'b0;
                        ext_r <= eng_sampling_length_r;
                        lat_r <= 4'h1 + half_res(o_core_res) + gain_delay(o_core_diff, o_core_gain);
                    end
                end
                ST_SAMPLE: begin
                    if (half && ext_r == 6'h00) begin
                        o_core_sample <= 1'b0;
                        state_r <= ST_CONVERT;
                    end else if (tick) begin
                        ext_r <= ext_r - 6'h01;
                    end
                end
                ST_CONVERT: begin
                    if (tick) begin
                        lat_r <= lat_r - 4'h1;
                        if (lat_r == 4'h1) begin
                            case (o_core_res)
                                adc_ctrl_pkg::RES_10: smp_r <= data_s2_r >> 2;
                                adc_ctrl_pkg::RES_8: smp_r <= data_s2_r >> 4;
                                default: smp_r <= data_s2_r;
                            endcase
                            acc_valid_r <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
            if (acc_valid_r) begin
                auto_r <= eng_free_r || !acc_last;
            end
        end
    end

    adc_accumulator u_acc (
        .i_clk(i_clk),
        .i_srst(rst),
        .i_clear(!o_core_enable),
        .i_valid(acc_valid_r),
        .i_sample(smp_r),
        .i_code(eng_avg_r),
        .o_last(acc_last),
        .o_done(acc_done),
        .o_result(acc_result)
    );

    // result and flags; a hardware set wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (rst) begin
            result_r <= 16'h0000;
            flags_r <= 2'h0;
            o_irq <= 1'b0;
        end else begin
            if (acc_done) begin
                result_r <= acc_result;
            end
            if (acc_done) begin
                flags_r[adc_ctrl_pkg::BIT_RESULT_READY_FLAG] <= 1'b1;
            end else if (rd_result || (wr && i_paddr == adc_ctrl_pkg::OFS_INTERRUPT_FLAG_REG && i_pwdata[0])) begin
                flags_r[adc_ctrl_pkg::BIT_RESULT_READY_FLAG] <= 1'b0;
            end
            if (acc_done && flags_r[adc_ctrl_pkg::BIT_RESULT_READY_FLAG] && !rd_result) begin
                flags_r[adc_ctrl_pkg::BIT_OVERRUN] <= 1'b1;
            end else if (wr && i_paddr == adc_ctrl_pkg::OFS_INTERRUPT_FLAG_REG && i_pwdata[1]) begin
                flags_r[adc_ctrl_pkg::BIT_OVERRUN] <= 1'b0;
            end
            o_irq <= |(flags_r & inten_r);
        end
    end
endmodule
`default_nettype wire

// file: verification/adc_ctrl_properties.sv
// port assertions for the conversion control block
// assumes binding into adc_conversion_control, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_properties (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_irq,
    input wire logic o_core_enable,
    input wire logic o_core_sample,
    input wire logic o_core_diff,
    input wire logic [3:0] o_core_gain,
    input wire logic [1:0] o_core_res
);
    logic wr_ok;
    logic diff_w;
    logic [1:0] res_w;
    logic [3:0] gain_w;
    assign wr_ok = i_psel && i_penable && i_pwrite && o_pready && !o_pslverr;
    // last committed configuration, for the converter-side copies
    always_ff @(posedge i_clk) begin
        if (wr_ok && i_paddr == 8'h04) begin
            res_w <= i_pwdata[5:4];
            diff_w <= i_pwdata[0];
        end
        if (wr_ok && i_paddr == 8'h10) begin
            gain_w <= i_pwdata[3:0];
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_pready_pulse: assert property (o_pready |=> !o_pready) else $error("pready held");
    a_pready_access: assert property (o_pready |-> i_psel && i_penable) else $error("pready off access");
    a_busy_bound: assert property (i_psel && !i_penable |-> ##[2:6] o_pready) else $error("no pready");
    a_cfg_follows: assert property (wr_ok && i_paddr == 8'h04 |=> ##[0:4] o_core_res == res_w &&
        o_core_diff == diff_w) else $error("config not passed");
    a_gain_follows: assert property (wr_ok && i_paddr == 8'h10 |=> ##[0:4] o_core_gain == gain_w)
        else $error("gain not passed");
    a_enable_on: assert property (wr_ok && i_paddr == 8'h00 && i_pwdata[1:0] == 2'h2 |=> ##[0:4] o_core_enable)
        else $error("enable lost");
    a_enable_off: assert property (wr_ok && i_paddr == 8'h00 && !i_pwdata[1] |=> ##[0:4] !o_core_enable)
        else $error("disable lost");
    a_soft_reset_bit_res: assert property (wr_ok && i_paddr == 8'h00 && i_pwdata[0] |=> ##[0:4] o_core_res == 2'h0)
        else $error("soft reset kept resolution");
    a_start_enabled: assert property ($rose(o_core_sample) |-> o_core_enable) else $error("start while off");
    c_trigger: cover property (wr_ok && i_paddr == 8'h18);
    c_irq: cover property ($rose(o_irq));
    c_refused: cover property (o_pslverr);
endmodule
bind adc_conversion_control adc_ctrl_properties i_props (.i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_irq, .o_core_enable, .o_core_sample, .o_core_diff,
    .o_core_gain, .o_core_res);
`default_nettype wire

// file: verification/adc_core_model.sv
// behavioural analog core: hands the bench's analog value to the control block
// assumes the value is set by the bench before a conversion starts
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    input wire logic i_clk,
    input wire logic i_enable,
    input wire logic [11:0] i_value,
    output logic [11:0] o_data
);
    logic [11:0] junk_r = 12'hA5A;
    // fixed reference: no result follows a reference change, so none is discarded
    // a powered-down core gives no stable code
    always @(posedge i_clk) begin
        junk_r <= ~junk_r + 12'h001;
    end
    assign o_data = i_enable ? i_value : junk_r;
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the conversion control block over APB
// assumes the analog core model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic i_event_start = 1'b0;
    logic [11:0] value = 12'hABC;
    logic [11:0] i_core_data;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_irq, o_core_enable, o_core_sample, o_core_diff;
    logic [3:0] o_core_gain;
    logic [1:0] o_core_res;
    logic [31:0] rd;
    logic err;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int base, lat, g, c;
    always #4 i_clk = ~i_clk;
    adc_conversion_control i_adc_conversion_control (.i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .i_event_start, .i_core_data, .o_prdata, .o_pready, .o_pslverr, .o_irq,
        .o_core_enable, .o_core_sample, .o_core_diff, .o_core_gain, .o_core_res);
    adc_core_model i_adc_core_model (.i_clk, .i_enable(o_core_enable), .i_value(value), .o_data(i_core_data));
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1) @(posedge i_clk);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    // one trigger after setup, no writes until the interrupt; cycles from sampling start
    task automatic conv(input logic ev, output int n);
        n = 0;
        if (ev) begin
            i_event_start <= 1'b1;
            repeat (2) @(posedge i_clk);
            i_event_start <= 1'b0;
        end else begin
            wr(8'h18, 32'h2);
        end
        while (o_core_sample !== 1'b1) @(posedge i_clk);
        while (o_irq !== 1'b1) begin
            n++;
            @(posedge i_clk);
        end
    endtask
    function automatic int gd(input int df, input int gc);
        if (gc == 15) return df ? 0 : 1;
        return df ? gc / 2 : (gc + 1) / 2;
    endfunction
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        rchk("control_b", 8'h04, 32'h0);
        apb(1'b0, 8'hFC, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        wr(8'h14, 32'h1);
        wr(8'h1C, 32'h1);
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h2);
        conv(1'b0, base);
        rchk("result", 8'h2C, 32'hABC);
        rchk("flags", 8'h24, 32'h0);
        for (int m = 0; m < 12; m++) begin
            g = (m % 6 == 5) ? 15 : m % 6;
            wr(8'h04, m < 6);
            wr(8'h10, g);
            value <= 12'hABC + 12'(m);
            conv(g[0], lat);
            chk("gain latency", base + 4 * gd(m < 6, g), lat);
            rchk("result", 8'h2C, 32'hABC + m);
        end
        value <= 12'hABC;
        wr(8'h10, 32'h0);
        for (int r = 2; r < 4; r++) begin
            wr(8'h04, 32'h1 | (r << 4));
            conv(1'b0, lat);
            chk("res latency", base - 4 * (r - 1), lat);
            rchk("res result", 8'h2C, 32'hABC >> (2 * (r - 1)));
        end
        wr(8'h04, 32'h101);
        conv(1'b0, lat);
        chk("prescaled latency", base + 28, lat);
        rchk("result", 8'h2C, 32'hABC);
        wr(8'h04, 32'h1);
        wr(8'h0C, 32'h2);
        conv(1'b0, lat);
        chk("sampling latency", base + 8, lat);
        rchk("result", 8'h2C, 32'hABC);
        wr(8'h0C, 32'h0);
        wr(8'h04, 32'h10);
        for (int k = 0; k < 3; k++) begin
            c = (k == 0) ? 2 : (k == 1) ? 5 : 11;
            wr(8'h08, c);
            conv(1'b0, lat);
            rchk("accumulated", 8'h2C, c > 10 ? 32'hABC : c < 5 ? 32'hABC << c : 32'hABC0);
        end
        wr(8'h08, 32'h0);
        rchk("sync busy", 8'h28, 32'h80);
        wr(8'h04, 32'h1);
        wr(8'h20, 32'h1);
        wr(8'h18, 32'h2);
        repeat (100) @(posedge i_clk);
        wr(8'h18, 32'h2);
        repeat (100) @(posedge i_clk);
        rchk("overrun", 8'h24, 32'h3);
        chk("masked irq", 32'h0, {31'h0, o_irq});
        wr(8'h24, 32'h3);
        rchk("flags", 8'h24, 32'h0);
        wr(8'h04, 32'h3);
        wr(8'h18, 32'h2);
        repeat (200) @(posedge i_clk);
        rchk("free run", 8'h24, 32'h3);
        wr(8'h04, 32'h1);
        repeat (100) @(posedge i_clk);
        wr(8'h24, 32'h3);
        wr(8'h30, 32'h1);
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h1);
        rchk("control_b", 8'h04, 32'h0);
        rchk("control_a", 8'h00, 32'h0);
        rchk("debug", 8'h30, 32'h1);
        test_done();
    end
endmodule
`default_nettype wire
